/* iabdc_ctrl.sv */
// abort cause recorder, slave nack control and dma enables
// assumes bit level engine reports ack results as one-cycle pulses
`include "iabdc_defs.svh"
module iabdc_ctrl (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        xfer_start,
	input  wire logic        xfer_startbyte,
	input  wire logic        xfer_gcall,
	input  wire logic        xfer_read,
	input  wire logic        ack_valid,
	input  wire logic        ack_seen,
	input  wire logic        ack_phase_hs,
	input  wire logic        ack_phase_addr2,
	input  wire logic        next_cmd_read,
	input  wire logic        next_cmd_valid,
	input  wire logic        abort_clear,
	output logic             xfer_abort,
	output logic             xfer_active,
	output logic             slave_ack_en,
	output logic             tx_dma_enable,
	output logic             rx_dma_enable,
	output logic             irq
);
	import iabdc_pkg::*;

	iabdc_state_t state;
	iabdc_abort_t abort_set;
	iabdc_abort_t abort_clr;
	iabdc_abort_t abort_bits;
	logic [2:0]   config_bits;
	logic         nack_ctrl;
	logic [1:0]   dma_ctrl;
	logic [1:0]   int_en;
	logic [1:0]   ev_set;
	logic [1:0]   ev_clr;
	logic [1:0]   int_stat;
	logic         gcall_sent;
	logic         addr_acked;
	logic         wr_hit;
	logic         rd_hit;
	logic         restart_ok;
	logic         hs_mode;
	logic         ten_bit;

	function automatic logic is_sel(input logic [7:0] a,
		input logic [7:0] off);
		is_sel = (a == off);
	endfunction : is_sel

	assign restart_ok = config_bits[`IABDC_CFG_RESTART];
	assign hs_mode    = config_bits[`IABDC_CFG_HS];
	assign ten_bit    = config_bits[`IABDC_CFG_TEN];

	// one wait cycle then answer; idle waitrequest stays high
	always_ff @(posedge clk) begin
		if (rst)
			avs_waitrequest <= 1'b1;
		else if ((avs_read || avs_write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end
	assign wr_hit = avs_write && !avs_waitrequest;
	assign rd_hit = avs_read && avs_waitrequest;

	// software writable registers
	always_ff @(posedge clk) begin
		if (rst) begin
			nack_ctrl   <= `IABDC_NACK_RST;
			dma_ctrl    <= `IABDC_DMA_RST;
			config_bits <= `IABDC_CFG_RST;
			int_en      <= 2'h0;
		end else if (wr_hit) begin
			if (is_sel(avs_address, `IABDC_OFF_NACK))
				nack_ctrl <= avs_writedata[0];
			if (is_sel(avs_address, `IABDC_OFF_DMA))
				dma_ctrl <= avs_writedata[1:0];
			if (is_sel(avs_address, `IABDC_OFF_CONFIG))
				config_bits <= avs_writedata[2:0];
			if (is_sel(avs_address, `IABDC_OFF_INT_EN))
				int_en <= avs_writedata[1:0];
		end
	end
	assign ev_clr = (wr_hit && is_sel(avs_address, `IABDC_OFF_INT_CLR))
		? avs_writedata[1:0] : 2'h0;

	// read mux, registered at the wait cycle; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (rst)
			avs_readdata <= 32'h0;
		else if (rd_hit) begin
			case (avs_address)
			`IABDC_OFF_NACK:     avs_readdata <= {31'h0, nack_ctrl};
			`IABDC_OFF_DMA:      avs_readdata <= {30'h0, dma_ctrl};
			`IABDC_OFF_ABORT:    avs_readdata <= {21'h0, abort_bits};
			`IABDC_OFF_CONFIG:   avs_readdata <= {29'h0, config_bits};
			`IABDC_OFF_INT_EN:   avs_readdata <= {30'h0, int_en};
			`IABDC_OFF_INT_STAT: avs_readdata <= {30'h0, int_stat};
			default:             avs_readdata <= 32'h0;
			endcase
		end
	end

	// abort cause decode, each from its own bus event
	always_comb begin
		abort_set = '0;
		if (xfer_start && !restart_ok) begin
			abort_set[10] = ten_bit && xfer_read;
			abort_set[9]  = xfer_startbyte;
			abort_set[8]  = hs_mode;
		end
		if (ack_valid && state == IABDC_ADDR) begin
			abort_set[7] = ack_seen && xfer_startbyte;
			abort_set[6] = ack_seen && ack_phase_hs;
			abort_set[4] = !ack_seen && gcall_sent;
			abort_set[2] = !ack_seen && ten_bit && ack_phase_addr2;
			abort_set[1] = !ack_seen && ten_bit && !ack_phase_addr2
				&& !gcall_sent && !ack_phase_hs;
			abort_set[0] = !ack_seen && !ten_bit && !gcall_sent
				&& !ack_phase_hs && !xfer_startbyte;
		end
		if (ack_valid && state == IABDC_DATA)
			abort_set[3] = !ack_seen && addr_acked;
		if (next_cmd_valid && gcall_sent && next_cmd_read
			&& state != IABDC_IDLE)
			abort_set[5] = 1'b1;
	end
	assign abort_clr = abort_clear ? '1 : '0;

	// transfer tracker; any abort drops it
	always_ff @(posedge clk) begin
		if (rst) begin
			state      <= IABDC_IDLE;
			gcall_sent <= 1'b0;
			addr_acked <= 1'b0;
		end else begin
			case (state)
			IABDC_IDLE: begin
				if (xfer_start && abort_set == '0) begin
					state      <= IABDC_ADDR;
					gcall_sent <= xfer_gcall;
					addr_acked <= 1'b0;
				end
			end
			IABDC_ADDR: begin
				if (abort_set != '0)
					state <= IABDC_ABORT;
				else if (ack_valid && ack_seen && !ack_phase_hs
					&& (!ten_bit || ack_phase_addr2)) begin
					state      <= IABDC_DATA;
					addr_acked <= 1'b1;
				end
			end
			IABDC_DATA: begin
				if (abort_set != '0)
					state <= IABDC_ABORT;
				else if (!xfer_start && !next_cmd_valid && !ack_valid)
					state <= IABDC_DATA;
			end
			IABDC_ABORT: state <= IABDC_IDLE;
			default:     state <= IABDC_IDLE;
			endcase
		end
	end

	// abort causes stay until software clears them
	iabdc_sticky #(.W(`IABDC_ABORT_W)) u_abort (
		.clk   (clk),
		.rst   (rst),
		.set_in(abort_set),
		.clr_in(abort_clr),
		.flags (abort_bits)
	);

	// events: bit0 abort, bit1 address phase acknowledged
	assign ev_set = {(state == IABDC_ADDR) && ack_valid && ack_seen,
		abort_set != '0};
	iabdc_sticky #(.W(`IABDC_EV_W)) u_int (
		.clk   (clk),
		.rst   (rst),
		.set_in(ev_set),
		.clr_in(ev_clr),
		.flags (int_stat)
	);

	// registered outputs toward the engine, dma and interrupt line
	always_ff @(posedge clk) begin
		if (rst) begin
			xfer_abort    <= 1'b0;
			xfer_active   <= 1'b0;
			slave_ack_en  <= 1'b0;
			tx_dma_enable <= 1'b0;
			rx_dma_enable <= 1'b0;
			irq           <= 1'b0;
		end else begin
			xfer_abort    <= (state != IABDC_IDLE) && (abort_set != '0);
			xfer_active   <= (state == IABDC_ADDR) || (state == IABDC_DATA);
			slave_ack_en  <= nack_ctrl;
			tx_dma_enable <= dma_ctrl[`IABDC_DMA_TX_BIT];
			rx_dma_enable <= dma_ctrl[`IABDC_DMA_RX_BIT];
			irq           <= |(int_stat & int_en);
		end
	end

	// each cause is checked from the bus event itself, not from abort_set
	hs_abort_a: assert property (@(posedge clk)
		disable iff (rst)
		xfer_start && !restart_ok && hs_mode |=> abort_bits[8])
		else $error("hs abort not set");
	sbyte_ack_a: assert property (@(posedge clk)
		disable iff (rst)
		ack_valid && ack_seen && xfer_startbyte && state == IABDC_ADDR
		|=> abort_bits[7])
		else $error("start byte ack abort missing");
	hs_code_ack_a: assert property (@(posedge clk)
		disable iff (rst)
		ack_valid && ack_seen && ack_phase_hs && state == IABDC_ADDR
		|=> abort_bits[6])
		else $error("hs master code ack abort missing");
	gcall_read_a: assert property (@(posedge clk)
		disable iff (rst)
		next_cmd_valid && next_cmd_read && gcall_sent
		&& state != IABDC_IDLE |=> abort_bits[5])
		else $error("general call read abort missing");
	gcall_noack_a: assert property (@(posedge clk)
		disable iff (rst)
		ack_valid && !ack_seen && gcall_sent && state == IABDC_ADDR
		|=> abort_bits[4])
		else $error("general call nack abort missing");
	data_noack_a: assert property (@(posedge clk)
		disable iff (rst)
		ack_valid && !ack_seen && state == IABDC_DATA
		|=> abort_bits[3])
		else $error("data byte nack abort missing");
	ten_second_a: assert property (@(posedge clk)
		disable iff (rst)
		ack_valid && !ack_seen && ten_bit && ack_phase_addr2
		&& state == IABDC_ADDR |=> abort_bits[2])
		else $error("second address byte abort missing");
	ten_first_a: assert property (@(posedge clk)
		disable iff (rst)
		ack_valid && !ack_seen && ten_bit && !ack_phase_addr2
		&& !gcall_sent && !ack_phase_hs && state == IABDC_ADDR
		|=> abort_bits[1])
		else $error("first address byte abort missing");
	seven_noack_a: assert property (@(posedge clk)
		disable iff (rst)
		ack_valid && !ack_seen && state == IABDC_ADDR && !ten_bit
		&& !gcall_sent && !ack_phase_hs && !xfer_startbyte
		|=> abort_bits[0])
		else $error("seven bit nack abort missing");
	abort_ends_a: assert property (@(posedge clk)
		disable iff (rst)
		state == IABDC_DATA && abort_set != '0
		|=> state == IABDC_ABORT ##1 state == IABDC_IDLE)
		else $error("abort did not end transfer");
	abort_pulse_a: assert property (@(posedge clk)
		disable iff (rst)
		(state == IABDC_ADDR || state == IABDC_DATA) && abort_set != '0
		|=> xfer_abort ##1 !xfer_active)
		else $error("abort pulse or drop missing");
	abort_hold_a: assert property (@(posedge clk)
		disable iff (rst)
		$rose(abort_bits[3]) && !abort_clear ##1 !abort_clear
		|-> abort_bits[3])
		else $error("abort bit dropped");
	read_only_a: assert property (@(posedge clk)
		disable iff (rst)
		wr_hit && is_sel(avs_address, `IABDC_OFF_ABORT)
		&& abort_set == '0 && !abort_clear
		|=> abort_bits == $past(abort_bits))
		else $error("abort register took a write");
	nack_out_a: assert property (@(posedge clk)
		disable iff (rst)
		wr_hit && is_sel(avs_address, `IABDC_OFF_NACK)
		|=> ##1 slave_ack_en == $past(avs_writedata[0], 2))
		else $error("slave ack follow wrong");
	tx_dma_a: assert property (@(posedge clk)
		disable iff (rst)
		tx_dma_enable == $past(dma_ctrl[1]))
		else $error("tx dma enable wrong");
	rx_dma_a: assert property (@(posedge clk)
		disable iff (rst)
		wr_hit && is_sel(avs_address, `IABDC_OFF_DMA) && avs_writedata[0]
		|=> ##1 rx_dma_enable)
		else $error("rx dma enable wrong");
	ten_rd_a: assert property (@(posedge clk)
		disable iff (rst)
		xfer_start && !restart_ok && ten_bit && xfer_read
		|=> abort_bits[10])
		else $error("ten bit read abort missing");
	sbyte_rs_a: assert property (@(posedge clk)
		disable iff (rst)
		xfer_start && !restart_ok && xfer_startbyte |=> abort_bits[9])
		else $error("start byte restart abort missing");
	wait_bound_a: assert property (@(posedge clk)
		disable iff (rst)
		(avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
		else $error("bus answer late");

	cov_data_nack_c: cover property (@(posedge clk) disable iff (rst)
		abort_set[3]);
	cov_gcall_c: cover property (@(posedge clk) disable iff (rst)
		abort_set[4]);
	cov_irq_c: cover property (@(posedge clk) disable iff (rst)
		$rose(irq));
	cov_addr_ok_c: cover property (@(posedge clk) disable iff (rst)
		state == IABDC_ADDR ##1 state == IABDC_DATA);
endmodule : iabdc_ctrl

/* iabdc_defs.svh */
// register offsets, field positions and reset values of the abort block
// assumes inclusion by bare name from the package and the modules
`ifndef IABDC_DEFS_SVH
`define IABDC_DEFS_SVH
`define IABDC_OFF_NACK     8'h84
`define IABDC_OFF_DMA      8'h88
`define IABDC_OFF_ABORT    8'h80
`define IABDC_OFF_CONFIG   8'h8C
`define IABDC_OFF_INT_EN   8'h90
`define IABDC_OFF_INT_CLR  8'h94
`define IABDC_OFF_INT_STAT 8'h98
`define IABDC_ABORT_W      11
`define IABDC_NACK_RST     1'h0
`define IABDC_DMA_RST      2'h0
`define IABDC_CFG_RST      3'h0
`define IABDC_DMA_RX_BIT   0
`define IABDC_DMA_TX_BIT   1
`define IABDC_CFG_RESTART  0
`define IABDC_CFG_HS       1
`define IABDC_CFG_TEN      2
`define IABDC_EV_W         2
`endif

/* iabdc_pkg.sv */
// types shared by the abort block
// assumes the defs header is on the include path
`include "iabdc_defs.svh"
package iabdc_pkg;
	typedef enum logic [3:0] {
		IABDC_IDLE  = 4'h1,
		IABDC_ADDR  = 4'h2,
		IABDC_DATA  = 4'h4,
		IABDC_ABORT = 4'h8
	} iabdc_state_t;
	typedef logic [`IABDC_ABORT_W-1:0] iabdc_abort_t;
endpackage : iabdc_pkg

/* iabdc_sticky.sv */
// sticky event flags with set-over-clear, registered output
// assumes set and clear pulses on the same clock
module iabdc_sticky #(
	parameter int W = 11
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] set_in,
	input  wire logic [W-1:0] clr_in,
	output logic      [W-1:0] flags
);
	// per-bit sticky, a set in the clear cycle survives
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst)
					flags[i] <= 1'b0;
				else if (set_in[i])
					flags[i] <= 1'b1;
				else if (clr_in[i])
					flags[i] <= 1'b0;
			end
		end
	endgenerate
endmodule : iabdc_sticky

/* iabdc_slave_model.sv */
// far-side model: answers each acknowledge slot with a one-cycle pulse
// assumes the bench calls answer() just after a rising clock edge
module iabdc_slave_model (
	input  wire logic clk,
	output logic      ack_valid,
	output logic      ack_seen,
	output logic      ack_phase_hs,
	output logic      ack_phase_addr2
);
	timeunit 1ns;
	timeprecision 1ns;
	// quiet bus before the first slot
	initial begin
		ack_valid = 1'b0;
		ack_seen = 1'b0;
		ack_phase_hs = 1'b0;
		ack_phase_addr2 = 1'b0;
	end
	// lat edges of delay allow slow slaves; a released line shows the
	// inverse level, so a stale value never passes for a real answer
	task automatic answer(input logic s, input logic h, input logic a2,
			input int lat);
		repeat (lat) @(posedge clk);
		ack_seen <= s;
		ack_phase_hs <= h;
		ack_phase_addr2 <= a2;
		ack_valid <= 1'b1;
		@(posedge clk);
		ack_valid <= 1'b0;
		ack_seen <= ~s;
		ack_phase_hs <= 1'b0;
		ack_phase_addr2 <= 1'b0;
	endtask : answer
endmodule : iabdc_slave_model

/* i2c_abort_and_nack_dma_ctrl_tb_top.sv */
// self-checking bench: register bus tasks, abort causes, interrupt
// assumes the abort block and its slave model are compiled first
module i2c_abort_and_nack_dma_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import iabdc_pkg::*;
	logic        clk, rst, avs_read, avs_write, xfer_start, xfer_startbyte;
	logic        xfer_gcall, xfer_read, next_cmd_read, next_cmd_valid;
	logic        abort_clear, ack_valid, ack_seen, ack_phase_hs, irq;
	logic        ack_phase_addr2, avs_waitrequest, xfer_abort, xfer_active;
	logic        slave_ack_en, tx_dma_enable, rx_dma_enable;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	int          failures, checks_done;
	int          abort_pulses = 0;
	iabdc_ctrl u_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .irq(irq),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .xfer_start(xfer_start),
		.xfer_startbyte(xfer_startbyte), .xfer_gcall(xfer_gcall),
		.xfer_read(xfer_read), .ack_valid(ack_valid), .ack_seen(ack_seen),
		.ack_phase_hs(ack_phase_hs), .ack_phase_addr2(ack_phase_addr2),
		.next_cmd_read(next_cmd_read), .next_cmd_valid(next_cmd_valid),
		.abort_clear(abort_clear), .xfer_abort(xfer_abort),
		.xfer_active(xfer_active), .slave_ack_en(slave_ack_en),
		.tx_dma_enable(tx_dma_enable), .rx_dma_enable(rx_dma_enable));
	iabdc_slave_model m (.clk(clk), .ack_valid(ack_valid),
		.ack_seen(ack_seen), .ack_phase_hs(ack_phase_hs),
		.ack_phase_addr2(ack_phase_addr2));
	// counts abort pulses toward the engine, read between transfers
	always @(posedge clk) begin
		if (xfer_abort)
			abort_pulses <= abort_pulses + 1;
	end
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one access held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			failures++;
			test_done();
		end
	endtask : bus
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rdchk
	// configure, request a transfer, play the slave's answers
	task automatic abort_case(input logic [2:0] cfg, input logic s,
			input logic g, input logic r, input logic pre, input logic ev,
			input logic sn, input logic hs, input logic a2, input logic nx,
			input int b);
		int p;
		p = abort_pulses;
		bus(1'b1, 8'h8C, {29'h0, cfg});
		@(posedge clk);
		xfer_startbyte <= s;
		xfer_gcall <= g;
		xfer_read <= r;
		xfer_start <= 1'b1;
		@(posedge clk);
		xfer_start <= 1'b0;
		if (pre) m.answer(1'b1, 1'b0, 1'b0, 2);
		if (ev) m.answer(sn, hs, a2, 3);
		@(posedge clk);
		next_cmd_read <= nx;
		next_cmd_valid <= nx;
		@(posedge clk);
		next_cmd_valid <= 1'b0;
		rdchk(8'h80, 32'h1 << b);
		chk({31'h0, xfer_active}, 32'h0);
		// causes found before a transfer starts have nothing to end
		chk(abort_pulses - p, (b < 8) ? 32'h1 : 32'h0);
		abort_clear <= 1'b1;
		@(posedge clk);
		abort_clear <= 1'b0;
		xfer_startbyte <= 1'b0;
		xfer_gcall <= 1'b0;
		xfer_read <= 1'b0;
		rdchk(8'h80, 32'h0);
	endtask : abort_case
	// main sequence
	initial begin
		{avs_read, avs_write, xfer_start, xfer_startbyte, xfer_gcall} = '0;
		{xfer_read, next_cmd_read, next_cmd_valid, abort_clear} = '0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		failures = 0;
		checks_done = 0;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdchk(8'h84, 32'h0);
		rdchk(8'h88, 32'h0);
		chk({31'h0, slave_ack_en}, 32'h0);
		bus(1'b1, 8'h84, 32'hFFFFFFFF);
		rdchk(8'h84, 32'h1);
		chk({31'h0, slave_ack_en}, 32'h1);
		bus(1'b1, 8'h88, 32'h2);
		rdchk(8'h88, 32'h2);
		chk({30'h0, tx_dma_enable, rx_dma_enable}, 32'h2);
		bus(1'b1, 8'h88, 32'h1);
		rdchk(8'h88, 32'h1);
		chk({30'h0, tx_dma_enable, rx_dma_enable}, 32'h1);
		bus(1'b1, 8'h80, 32'hFFFFFFFF);
		rdchk(8'h80, 32'h0);
		rdchk(8'hFC, 32'h0);
		$display("test registers done");
		abort_case(3'h1, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0);
		abort_case(3'h5, 0, 0, 0, 0, 1, 0, 0, 0, 0, 1);
		abort_case(3'h5, 0, 0, 0, 1, 1, 0, 0, 1, 0, 2);
		abort_case(3'h1, 0, 0, 0, 1, 1, 0, 0, 0, 0, 3);
		abort_case(3'h1, 0, 1, 0, 0, 1, 0, 0, 0, 0, 4);
		abort_case(3'h1, 0, 1, 0, 1, 0, 0, 0, 0, 1, 5);
		abort_case(3'h3, 0, 0, 0, 0, 1, 1, 1, 0, 0, 6);
		abort_case(3'h1, 1, 0, 0, 0, 1, 1, 0, 0, 0, 7);
		abort_case(3'h2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8);
		abort_case(3'h0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 9);
		abort_case(3'h4, 0, 0, 1, 0, 0, 0, 0, 0, 0, 10);
		$display("test abort causes done");
		bus(1'b1, 8'h94, 32'h3);
		bus(1'b1, 8'h90, 32'h1);
		abort_case(3'h1, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 8'h90, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h90, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 8'h94, 32'h3);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdchk(8'h98, 32'h0);
		$display("test interrupt done");
		test_done();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		test_done();
	end
endmodule : i2c_abort_and_nack_dma_ctrl_tb_top
